// ===== design/fsq_pkg.sv
// Purpose: Shared constants and types of the flash sequencer end-address
//          and status block.
// Assumes: One 25 MHz clock, peripheral bus with byte enables.
// Notes: All addresses are byte addresses on the peripheral bus.
package fsq_pkg;

	// Register byte addresses.
	localparam logic [31:0] STATUS_ADDR = 32'hFFA10080;
	localparam logic [31:0] END_ADDR_ADDR = 32'hFFA10034;
	localparam logic [31:0] ECC_PORT_ADDR = 32'hFFA10038;

	// Values after reset.
	localparam logic [31:0] STATUS_RESET = 32'h00008000;
	localparam logic [31:0] END_ADDR_RESET = 32'h00000000;

	// Status bit positions.
	localparam int EBF_BIT = 18;
	localparam int OTP_BIT = 17;
	localparam int IDLE_BIT = 15;
	localparam int ILLEGAL_BIT = 14;

	// Depth of the ECC word buffer, in words.
	localparam logic [1:0] ECC_DEPTH = 2'h2;

	// Lowest end address (bits 18..0) that a blank check refuses.
	localparam logic [18:0] BC_LIMIT_DEFAULT = 19'h40000;

	// Kind of command that the rest of the sequencer starts.
	typedef enum logic [2:0] {
		OP_NONE,
		OP_CF_PROGRAM,
		OP_BLOCK_ERASE,
		OP_LOCK_PROGRAM,
		OP_LOCK_READ,
		OP_OTP_SET,
		OP_BLANK_CHECK,
		OP_OTHER
	} fsq_op_t;

	// One peripheral bus request.
	typedef struct packed {
		logic sel;
		logic wr;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} fsq_bus_req_t;

endpackage : fsq_pkg

// ===== design/fsq_end_status.sv
// Purpose: Blank-check end address register with its checks, and the
//          low flags of the sequencer status register.
// Assumes: All inputs come from logic on clk_in; bus reads answer one
//          cycle after the request.
// Notes: Status flags other than bits 18, 17, 15 and 14 read as zero.
`timescale 1ns/1ps

// Function
// - End register gives blank check final address.
// - Bad ordering locks instead of checking.
// - End register resets on reset or init.
// - Only end address bits 18..2 used.
// - End bits in refused range raise error.
// - Status readable as word, halves, low bytes.
// - Status reads 0x00008000 after reset.
// - Reserved status bits 31..19 read zero.
// - Buffer full flag follows ECC buffer fill.
// - ECC port write stalls bus while full.
// - OTP double error sets flag and locks.
// - OTP checked on five listed operations.
// - OTP flag clears on clear or stop.
// - Idle flag low while command runs.
// - Illegal error flag set, sequencer locks.
module fsq_end_status #(
	parameter logic [18:0] BC_LIMIT = fsq_pkg::BC_LIMIT_DEFAULT
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Peripheral bus.
	input wire fsq_pkg::fsq_bus_req_t bus_in,
	output logic [31:0] bus_rdata_out,
	output logic bus_wait_out,
	// Sequencer control.
	input wire logic init_in,
	input wire logic busy_in,
	input wire logic op_start_in,
	input wire fsq_pkg::fsq_op_t op_in,
	input wire logic [23:0] start_addr_in,
	input wire logic direction_in,
	input wire logic status_clear_in,
	input wire logic forced_stop_in,
	input wire logic illegal_in,
	// OTP read.
	output logic otp_read_req_out,
	input wire logic otp_valid_in,
	input wire logic otp_double_err_in,
	// ECC buffer drain.
	output logic ecc_push_out,
	output logic [31:0] ecc_data_out,
	input wire logic ecc_drain_in,
	// Blank check launch.
	output logic bc_go_out,
	output logic [31:0] bc_end_out,
	output logic locked_out
);

	// Effective address bits used by command processing.
	function automatic logic [16:0] eff_addr(input logic [31:0] a);
		eff_addr = a[18:2];
	endfunction : eff_addr

	logic [31:0] end_addr_ff;
	logic [31:0] rdata_ff;
	logic [1:0] ecc_cnt_ff;
	logic [31:0] ecc_data_ff;
	logic ecc_push_ff;
	logic otp_ff;
	logic illegal_ff;
	logic idle_ff;
	logic bc_go_ff;
	logic [31:0] bc_end_ff;
	logic [1:0] nxt_ecc_cnt;

	// Address decode and bus strobes.
	wire hit_status = bus_in.sel
		&& bus_in.addr[31:2] == fsq_pkg::STATUS_ADDR[31:2];
	wire hit_end = bus_in.sel
		&& bus_in.addr[31:2] == fsq_pkg::END_ADDR_ADDR[31:2];
	wire hit_ecc = bus_in.sel
		&& bus_in.addr[31:2] == fsq_pkg::ECC_PORT_ADDR[31:2];
	wire ecc_full = ecc_cnt_ff == fsq_pkg::ECC_DEPTH;
	wire ecc_stall = hit_ecc && bus_in.wr && ecc_full;
	wire ecc_wr = hit_ecc && bus_in.wr && !ecc_full;
	wire end_wr = hit_end && bus_in.wr;

	// Blank check decision from direction, start and end.
	wire bc_start = op_start_in && op_in == fsq_pkg::OP_BLANK_CHECK;
	wire [16:0] end_eff = eff_addr(end_addr_ff);
	wire [16:0] start_eff = eff_addr({8'h00, start_addr_in});
	wire order_bad = direction_in ? !(end_eff < start_eff)
		: !(end_eff > start_eff);
	wire range_bad = end_addr_ff[18:0] >= BC_LIMIT;
	wire bc_err = bc_start && (order_bad || range_bad || locked_out);
	wire bc_ok = bc_start && !bc_err;

	// OTP is read only for the operations that depend on it.
	wire otp_op = op_in == fsq_pkg::OP_CF_PROGRAM
		|| op_in == fsq_pkg::OP_BLOCK_ERASE
		|| op_in == fsq_pkg::OP_LOCK_PROGRAM || op_in == fsq_pkg::OP_LOCK_READ
		|| op_in == fsq_pkg::OP_OTP_SET;
	assign otp_read_req_out = op_start_in && otp_op;
	wire otp_set = otp_valid_in && otp_double_err_in;
	wire flag_clr = status_clear_in || forced_stop_in;
	// An OTP double error locks through its own flag, not the illegal one.
	wire illegal_set = illegal_in || bc_err;

	// Status word; reserved and foreign bits stay zero.
	wire [31:0] status_word = {13'h0000, ecc_full, otp_ff, 1'b0, idle_ff,
		illegal_ff, 14'h0000};

	// The top byte has no byte view of its own, so lone lane 3 reads empty.
	wire [31:0] lane_mask = {{8{bus_in.be[3] && bus_in.be[2]}},
		{8{bus_in.be[2]}}, {8{bus_in.be[1]}}, {8{bus_in.be[0]}}};
	wire [31:0] read_word = hit_status ? status_word & lane_mask
		: hit_end ? end_addr_ff & lane_mask : 32'h00000000;

	// Buffer occupancy; a push and a drain together leave it unchanged unless it is empty.
	always_comb
	begin
		nxt_ecc_cnt = ecc_cnt_ff;
		if (ecc_wr && !(ecc_drain_in && ecc_cnt_ff != 2'h0))
			nxt_ecc_cnt = ecc_cnt_ff + 2'h1;
		else if (!ecc_wr && ecc_drain_in && ecc_cnt_ff != 2'h0)
			nxt_ecc_cnt = ecc_cnt_ff - 2'h1;
	end

	// Bus answer; the stall holds the master until a slot frees.
	assign bus_wait_out = ecc_stall;
	assign bus_rdata_out = rdata_ff;
	assign ecc_push_out = ecc_push_ff;
	assign ecc_data_out = ecc_data_ff;
	assign bc_go_out = bc_go_ff;
	assign bc_end_out = bc_end_ff;
	assign locked_out = illegal_ff || otp_ff;

	// End address register, byte-lane writable.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			end_addr_ff <= fsq_pkg::END_ADDR_RESET;
		else if (init_in)
			end_addr_ff <= fsq_pkg::END_ADDR_RESET;
		else if (end_wr)
			for (int i = 0; i < 4; i++)
				if (bus_in.be[i])
					end_addr_ff[8*i +: 8] <= bus_in.wdata[8*i +: 8];
	end

	// Read data and ECC buffer path; status writes land nowhere.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rdata_ff <= 32'h00000000;
			ecc_cnt_ff <= 2'h0;
			ecc_data_ff <= 32'h00000000;
			ecc_push_ff <= 1'b0;
		end
		else
		begin
			rdata_ff <= (bus_in.sel && !bus_in.wr) ? read_word : rdata_ff;
			ecc_cnt_ff <= nxt_ecc_cnt;
			ecc_push_ff <= ecc_wr;
			ecc_data_ff <= ecc_wr ? bus_in.wdata : ecc_data_ff;
		end
	end

	// Status flags; a set in the clearing cycle wins.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			otp_ff <= fsq_pkg::STATUS_RESET[fsq_pkg::OTP_BIT];
			illegal_ff <= fsq_pkg::STATUS_RESET[fsq_pkg::ILLEGAL_BIT];
			idle_ff <= fsq_pkg::STATUS_RESET[fsq_pkg::IDLE_BIT];
		end
		else
		begin
			otp_ff <= otp_set || (otp_ff && !flag_clr);
			illegal_ff <= illegal_set || (illegal_ff && !flag_clr);
			idle_ff <= !busy_in;
		end
	end

	// Blank check launch with the effective end address.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			bc_go_ff <= 1'b0;
			bc_end_ff <= 32'h00000000;
		end
		else
		begin
			bc_go_ff <= bc_ok;
			bc_end_ff <= bc_ok ? {13'h0000, end_eff, 2'h0} : bc_end_ff;
		end
	end

	// All properties sample on the rising edge and rest during reset.
	default clocking cb_main @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	AST_ORDER_LOCKS: assert property (
		bc_start && order_bad |=> !bc_go_out && locked_out)
		else $error("Badly ordered blank check was launched.");

	AST_RANGE_LOCKS: assert property (
		bc_start && range_bad |=> illegal_ff && !bc_go_out)
		else $error("Blank check in refused range did not error.");

	AST_END_USED: assert property (
		bc_go_out |-> bc_end_out == {13'h0000, $past(end_addr_ff[18:2]), 2'h0})
		else $error("Launched end address differs from register.");

	AST_INIT_CLEARS: assert property (
		init_in |=> end_addr_ff == fsq_pkg::END_ADDR_RESET)
		else $error("Init did not reset the end address.");

	AST_RESERVED_ZERO: assert property (
		$past(hit_status && !bus_in.wr) |-> bus_rdata_out[31:19] == 13'h0000)
		else $error("Reserved status bits read nonzero.");

	// A stalled write must neither pass nor be pushed into the buffer.
	AST_FULL_WAITS: assert property (
		hit_ecc && bus_in.wr && ecc_cnt_ff == fsq_pkg::ECC_DEPTH
		|-> bus_wait_out ##1 !ecc_push_out)
		else $error("Write to full ECC buffer not stalled.");

	AST_FULL_FLAG: assert property (
		ecc_cnt_ff == 2'h1 && ecc_wr && !ecc_drain_in
		|=> status_word[fsq_pkg::EBF_BIT])
		else $error("Buffer full flag missed the fill.");

	AST_OTP_LOCK: assert property (
		otp_set |=> status_word[fsq_pkg::OTP_BIT] && locked_out)
		else $error("OTP double error not flagged.");

	AST_OTP_CLEAR: assert property (
		flag_clr && !otp_set |=> !otp_ff)
		else $error("OTP flag survived a clear.");

	AST_IDLE: assert property (
		busy_in [*2] |-> !idle_ff)
		else $error("Idle shown while busy.");

	AST_WRITE_IGNORED: assert property (
		hit_status && bus_in.wr && !illegal_set && !flag_clr
		|=> $stable(illegal_ff) && $stable(otp_ff))
		else $error("Status write changed a flag.");

	CV_BC_GO: cover property (bc_go_out);
	CV_STALL: cover property (bus_wait_out [*2] ##1 !bus_wait_out);
	CV_OTP: cover property (otp_set ##[1:20] flag_clr);
	CV_BAD_ORDER: cover property (bc_start && order_bad && direction_in);

endmodule : fsq_end_status

// ===== verification/fsq_host_model.sv
// Purpose: Host side of the peripheral bus for the status block bench.
// Assumes: Requests start at a falling edge.
// Notes: Released address and data lines carry inverted values; select, write and byte enables go low.
`timescale 1ns/1ps
module fsq_host_model (
	// Clock and bus.
	input wire logic clk_in,
	input wire logic bus_wait_in,
	output fsq_pkg::fsq_bus_req_t bus_out
);
	logic w;
	initial bus_out = '0;
	// Holds the request until an edge with wait low takes it.
	task automatic xfer(input logic r, input logic [31:0] a,
		input logic [3:0] m, input logic [31:0] d);
		@(negedge clk_in);
		bus_out = '{1'b1, r, a, m, d};
		do
		begin
			#1 w = bus_wait_in;
			@(posedge clk_in);
		end
		while (w);
		@(negedge clk_in);
		// Stale address and data would hide a late sample.
		bus_out = '{1'b0, 1'b0, ~a, 4'h0, ~d};
	endtask : xfer
endmodule : fsq_host_model

// ===== verification/flash_seq_end_addr_status_bench.sv
// Purpose: Self-checking bench of the end-address and status block.
// Assumes: Inputs change at the falling edge; results are queued notes.
// Notes: BC_LIMIT takes a bound below the default to exercise the parameter.
`timescale 1ns/1ps
module flash_seq_end_addr_status_bench;
	localparam logic [31:0] ST = fsq_pkg::STATUS_ADDR;
	localparam logic [31:0] EA = fsq_pkg::END_ADDR_ADDR;
	localparam logic [31:0] EP = fsq_pkg::ECC_PORT_ADDR;
	logic clk_in = 1'b0, rst_n_in = 1'b0, rd_tk = 1'b0, b;
	logic init_in = 1'b0, busy_in = 1'b0, op_start_in = 1'b0;
	logic direction_in = 1'b0, status_clear_in = 1'b0, forced_stop_in = 1'b0;
	logic illegal_in = 1'b0, otp_valid_in = 1'b0, otp_double_err_in = 1'b0;
	logic ecc_drain_in = 1'b0, bus_wait_out, otp_read_req_out, ecc_push_out;
	logic bc_go_out, locked_out;
	logic [23:0] start_addr_in = 24'h0;
	logic [31:0] bus_rdata_out, ecc_data_out, bc_end_out, e, seed = 32'h51AF;
	logic [3:0] bes [6] = '{4'hF, 4'h3, 4'hC, 4'h1, 4'h2, 4'h4};
	logic [31:0] q [$];
	fsq_pkg::fsq_op_t op_in = fsq_pkg::OP_NONE;
	fsq_pkg::fsq_bus_req_t bus_in;
	int failures = 0, tests_run = 0, cycles = 0;

	fsq_host_model u_fsq_host_model (.clk_in, .bus_wait_in(bus_wait_out),
		.bus_out(bus_in));
	fsq_end_status #(.BC_LIMIT(19'h10000)) u_fsq_end_status (.clk_in,
		.rst_n_in, .bus_in, .bus_rdata_out, .bus_wait_out, .init_in,
		.busy_in, .op_start_in, .op_in, .start_addr_in, .direction_in,
		.status_clear_in, .forced_stop_in, .illegal_in, .otp_read_req_out,
		.otp_valid_in, .otp_double_err_in, .ecc_push_out, .ecc_data_out,
		.ecc_drain_in, .bc_go_out, .bc_end_out, .locked_out);

	// Free-running 25 MHz clock.
	always #20 clk_in = ~clk_in;

	// Watchdog; the whole run needs well under a thousand cycles.
	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			failures = failures + 1;
			conclude();
		end
	end

	// Result watcher: each visible result takes the oldest note.
	always @(posedge clk_in) rd_tk <= bus_in.sel && !bus_in.wr;
	always @(negedge clk_in)
	begin
		if (rd_tk)
			cmp("rdata", bus_rdata_out);
		if (bc_go_out)
			cmp("bc_end", bc_end_out);
		if (ecc_push_out)
			cmp("ecc_data", ecc_data_out);
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic chk(input string n, input logic [31:0] x, g);
		tests_run++;
		if (g !== x)
		begin
			$display("[ERR] %s expected %h seen %h", n, x, g);
			failures++;
		end
	endtask : chk

	task automatic cmp(input string n, input logic [31:0] g);
		logic [31:0] x;
		// An empty queue always mismatches, so a stray result is caught.
		x = (g === 32'h0) ? 32'h1 : 32'h0;
		if (q.size() > 0)
			x = q.pop_front();
		chk(n, x, g);
	endtask : cmp

	task automatic pulse(ref logic s);
		@(negedge clk_in);
		s = 1'b1;
		@(negedge clk_in);
		s = 1'b0;
	endtask : pulse

	task automatic wr(input logic [31:0] a, input logic [3:0] m,
		input logic [31:0] d);
		u_fsq_host_model.xfer(1'b1, a, m, d);
	endtask : wr

	// Lane three only answers together with lane two.
	task automatic rd(input logic [31:0] a, input logic [3:0] m,
		input logic [31:0] x);
		q.push_back(x & {{8{m[3] & m[2]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}});
		u_fsq_host_model.xfer(1'b0, a, m, 32'h0);
	endtask : rd

	task automatic op(input logic [2:0] k);
		@(negedge clk_in);
		op_in = fsq_pkg::fsq_op_t'(k);
		op_start_in = 1'b1;
		b = k inside {[3'h1:3'h5]};
		#1 chk("otp_req", {31'h0, b}, {31'h0, otp_read_req_out});
		@(negedge clk_in);
		op_start_in = 1'b0;
	endtask : op

	// A refused blank check locks and is unlocked by a status clear.
	task automatic bc(input logic d, input logic [23:0] s,
		input logic [31:0] x, input logic ok);
		wr(EA, 4'hF, x);
		direction_in = d;
		start_addr_in = s;
		if (ok)
			q.push_back({13'h0, x[18:2], 2'h0});
		op(3'h6);
		if (!ok)
		begin
			chk("locked", 32'h1, {31'h0, locked_out});
			rd(ST, 4'hF, 32'h0000C000);
			pulse(status_clear_in);
			chk("locked", 32'h0, {31'h0, locked_out});
		end
	endtask : bc

	task conclude;
		if (failures == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
		foreach (bes[i]) rd(ST, bes[i], fsq_pkg::STATUS_RESET);
		wr(ST, 4'hF, 32'hFFFFFFFF);
		rd(ST, 4'hF, fsq_pkg::STATUS_RESET);
		e = xs();
		wr(EA, 4'hF, e);
		rd(EA, 4'hF, e);
		pulse(init_in);
		rd(EA, 4'hF, fsq_pkg::END_ADDR_RESET);
		e = (xs() & 32'hFFF87FFF) | 32'h00008000;
		bc(1'b0, 24'h000100, e, 1'b1);
		bc(1'b1, 24'h00F000, 32'h00000100, 1'b1);
		bc(1'b0, 24'h000100, 32'h00000100, 1'b0);
		bc(1'b1, 24'h000100, 32'h00000200, 1'b0);
		bc(1'b0, 24'h000000, 32'h00010000, 1'b0);
		bc(1'b0, 24'h000000, 32'h0000FFFC, 1'b1);
		for (int k = 0; k < 8; k++)
			if (k != 6)
				op(k[2:0]);
		@(negedge clk_in);
		otp_valid_in = 1'b1;
		otp_double_err_in = 1'b1;
		@(negedge clk_in);
		otp_valid_in = 1'b0;
		otp_double_err_in = 1'b0;
		chk("locked", 32'h1, {31'h0, locked_out});
		rd(ST, 4'hF, 32'h00028000);
		pulse(forced_stop_in);
		rd(ST, 4'hF, 32'h00008000);
		pulse(illegal_in);
		rd(ST, 4'hF, 32'h0000C000);
		pulse(forced_stop_in);
		busy_in = 1'b1;
		rd(ST, 4'hF, 32'h00000000);
		busy_in = 1'b0;
		e = xs();
		q.push_back(e);
		wr(EP, 4'hF, e);
		q.push_back(~e);
		wr(EP, 4'hF, ~e);
		rd(ST, 4'hF, 32'h00048000);
		q.push_back(e ^ 32'h5A5A5A5A);
		fork
			wr(EP, 4'hF, e ^ 32'h5A5A5A5A);
			begin
				repeat (3) @(negedge clk_in);
				#1 chk("wait", 32'h1, {31'h0, bus_wait_out});
				pulse(ecc_drain_in);
			end
		join
		pulse(ecc_drain_in);
		pulse(ecc_drain_in);
		rd(ST, 4'hF, fsq_pkg::STATUS_RESET);
		// Let the last answer be compared; no note may be left over.
		@(posedge clk_in);
		chk("notes_left", 32'h0, 32'(q.size()));
		conclude();
	end
endmodule : flash_seq_end_addr_status_bench
